/* File: gpb_port.sv */
// Two general-purpose ports with change interrupt, behind an AXI4-Lite slave.
// How it works
// R1 - Direction bit 1 makes a pin input, 0 drives the output latch.
// R2 - Active-low option bit 7 enables all first-port weak pull-ups.
// R3 - A pin's pull-up is off while that pin drives as output.
// R4 - Reset sets the option register to all ones, pull-ups off.
// R5 - Analog select chooses analog or digital; analog pins read zero.
// R6 - Only the upper four first-port input pins are change-monitored.
// R7 - Monitored pins differ from snapshot: OR of mismatches sets change flag.
// R8 - The change flag wakes the device from sleep.
// R9 - Any read or write of first-port data refreshes the snapshot.
// R10 - A lasting mismatch keeps setting the flag; clear fails until read.
// R11 - Software should not poll the first port when using change interrupts.
// R12 - First-port pin 0 is an external interrupt, edge chosen by bit 6.
// R13 - An owning peripheral overrides the direction bit of its pin.
// R14 - Software should avoid read-modify-write of direction under override.
// R15 - Second-port pin output comes from latch or peripheral by select.
// R16 - Peripheral output enable acts only while its select is active.
// R17 - Data reads return pin levels; writes change only the latch.
// R18 - Pin inputs are synchronised before comparison and read.
module gpb_port
  import gpb_pkg::*;
#(
  parameter int ADDR_W = GPB_ADDR_W
) (
  input wire logic aclk, // Core clock, 20 MHz.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [ADDR_W-1:0] s_awaddr, // Write address.
  input wire logic s_awvalid, // Write address valid.
  output logic s_awready, // Write address ready.
  input wire logic [31:0] s_wdata, // Write data.
  input wire logic [3:0] s_wstrb, // Write byte strobes.
  input wire logic s_wvalid, // Write data valid.
  output logic s_wready, // Write data ready.
  output logic [1:0] s_bresp, // Write response.
  output logic s_bvalid, // Write response valid.
  input wire logic s_bready, // Write response ready.
  input wire logic [ADDR_W-1:0] s_araddr, // Read address.
  input wire logic s_arvalid, // Read address valid.
  output logic s_arready, // Read address ready.
  output logic [31:0] s_rdata, // Read data.
  output logic [1:0] s_rresp, // Read response.
  output logic s_rvalid, // Read data valid.
  input wire logic s_rready, // Read data ready.
  input wire logic [7:0] pb_in, // First-port pin levels.
  output logic [7:0] pb_out, // First-port drive values.
  output logic [7:0] pb_oe, // First-port drive enables, high drives.
  output logic [7:0] pb_pullup, // First-port weak pull-up enables.
  input wire gpb_periph_t pb_periph, // Peripheral claim on first port.
  input wire logic [7:0] pc_in, // Second-port pin levels.
  output logic [7:0] pc_out, // Second-port drive values.
  output logic [7:0] pc_oe, // Second-port drive enables, high drives.
  input wire gpb_periph_t pc_periph, // Peripheral claim on second port.
  input wire logic sleep_mode, // Core is asleep.
  output logic wake, // Request to leave sleep.
  output logic irq // Level interrupt.
);

  // Word indices above the address width could never be reached.
  initial begin
    if (ADDR_W < GPB_ADDR_W) begin
      $error("gpb_port: ADDR_W too small for the register map");
    end
  end

  // Effective direction, 1 means input; a peripheral claim wins.
  function automatic logic [7:0] gpb_eff_dir(input logic [7:0] dir,
                                             input gpb_periph_t p);
    gpb_eff_dir = (p.own & ~p.oe) | (~p.own & dir);
  endfunction

  // True for every index that has a register behind it.
  function automatic logic gpb_mapped(input logic [7:0] idx);
    gpb_mapped = (idx == GPB_IDX_PB_DATA) || (idx == GPB_IDX_PC_DATA) ||
                 (idx == GPB_IDX_INTCTL) || (idx == GPB_IDX_OPTION) ||
                 (idx == GPB_IDX_PB_DIR) || (idx == GPB_IDX_PC_DIR) ||
                 (idx == GPB_IDX_ANALOG) || (idx == GPB_IDX_IRQ_STAT) ||
                 (idx == GPB_IDX_IRQ_MASK);
  endfunction

  logic [7:0] option_control;
  logic [7:0] first_port_direction;
  logic [7:0] second_port_direction;
  logic [7:0] analog_select_control;
  logic [7:0] first_port_latch;
  logic [7:0] second_port_latch;
  logic [1:0] interrupt_control;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;
  logic [7:0] change_snapshot;
  logic ext_pin_q;
  logic [ADDR_W-1:0] aw_q;
  logic [7:0] wd_q;
  logic ws_q;
  logic [7:0] pb_sync;
  logic [7:0] pc_sync;

  // Pins are brought into the core domain before any use. [R18]
  gpb_sync #(.W(8)) u_sync_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pb_in),
    .dout(pb_sync)
  );
  gpb_sync #(.W(8)) u_sync_c (
    .aclk(aclk),
    .aresetn(aresetn),
    .din(pc_in),
    .dout(pc_sync)
  );

  // Pin-side decode: direction, digital view and change compare.
  wire [7:0] eff_dir_b = gpb_eff_dir(first_port_direction, pb_periph); // [R13]
  wire [7:0] eff_dir_c = gpb_eff_dir(second_port_direction, pc_periph); // [R16]
  wire [7:0] pb_digital = pb_sync & analog_select_control; // [R5]
  wire [7:0] monitored = GPB_UPPER_MASK & eff_dir_b; // [R6]
  wire mismatch = |((pb_digital ^ change_snapshot) & monitored); // [R7]
  wire ext_pin = pb_digital[0];
  wire ext_edge = option_control[GPB_OPT_EDGE] ? (ext_pin & ~ext_pin_q)
                                               : (~ext_pin & ext_pin_q); // [R12]
  wire [1:0] events = {ext_edge, mismatch};

  // Drive values; the port latch only reaches a pin no peripheral owns. [R15]
  wire [7:0] next_pb_out = (pb_periph.own & pb_periph.dout) |
                           (~pb_periph.own & first_port_latch);
  wire [7:0] next_pc_out = (pc_periph.own & pc_periph.dout) |
                           (~pc_periph.own & second_port_latch); // [R15]
  wire [7:0] next_pb_pullup = eff_dir_b &
                              {8{~option_control[GPB_OPT_PULLUP_N]}}; // [R2] [R3]

  // Bus decode. A write goes ahead once address and data are both held.
  wire rd_go = s_arvalid & s_arready;
  wire [7:0] rd_idx = s_araddr[GPB_IDX_LSB +: 8];
  wire wr_go = ~s_awready & ~s_wready & ~s_bvalid;
  wire [7:0] wr_idx = aw_q[GPB_IDX_LSB +: 8];
  wire wr_ok = gpb_mapped(wr_idx);
  wire wr_en = wr_go & wr_ok & ws_q;
  wire pb_touch = (rd_go & (rd_idx == GPB_IDX_PB_DATA)) |
                  (wr_go & (wr_idx == GPB_IDX_PB_DATA)); // [R9]
  wire stat_read = rd_go & (rd_idx == GPB_IDX_IRQ_STAT);

  // Read selection; direction reads show the override in force. [R14]
  wire [7:0] rd_byte =
    (rd_idx == GPB_IDX_PB_DATA) ? pb_digital : // [R17]
    (rd_idx == GPB_IDX_PC_DATA) ? pc_sync :
    (rd_idx == GPB_IDX_INTCTL) ? {6'h00, interrupt_control} :
    (rd_idx == GPB_IDX_OPTION) ? option_control :
    (rd_idx == GPB_IDX_PB_DIR) ? eff_dir_b :
    (rd_idx == GPB_IDX_PC_DIR) ? eff_dir_c :
    (rd_idx == GPB_IDX_ANALOG) ? analog_select_control :
    (rd_idx == GPB_IDX_IRQ_STAT) ? {6'h00, irq_status} :
    (rd_idx == GPB_IDX_IRQ_MASK) ? {6'h00, irq_mask} : 8'h00;

  // Flags: a hardware set always beats a software clear in the same cycle,
  // so a lasting mismatch re-sets the flag every cycle. [R10]
  wire [1:0] intctl_base = (wr_en && wr_idx == GPB_IDX_INTCTL) ?
                           wd_q[1:0] : interrupt_control;
  wire [1:0] next_intctl = intctl_base | events; // [R7] [R12]
  wire [1:0] next_status = (stat_read ? 2'h0 : irq_status) | events;

  // Write address and data channels, taken in either order.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_awready <= 1'b1;
      s_wready <= 1'b1;
      s_bvalid <= 1'b0;
      s_bresp <= GPB_RESP_OKAY;
      aw_q <= '0;
      wd_q <= 8'h00;
      ws_q <= 1'b0;
    end else begin
      if (s_awvalid && s_awready) begin
        s_awready <= 1'b0;
        aw_q <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        s_wready <= 1'b0;
        wd_q <= s_wdata[7:0];
        ws_q <= s_wstrb[0];
      end
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp <= wr_ok ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
      end else if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
        s_awready <= 1'b1;
        s_wready <= 1'b1;
      end
    end
  end

  // Read channel; data is captured at the address handshake.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b1;
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= GPB_RESP_OKAY;
    end else if (rd_go) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b1;
      s_rdata <= {24'h00_0000, rd_byte};
      s_rresp <= gpb_mapped(rd_idx) ? GPB_RESP_OKAY : GPB_RESP_SLVERR;
    end else if (s_rvalid && s_rready) begin
      s_rvalid <= 1'b0;
      s_arready <= 1'b1;
    end
  end

  // Software-written configuration. Only byte lane 0 carries data.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_control <= GPB_RST_OPTION; // [R4]
      first_port_direction <= GPB_RST_DIR;
      second_port_direction <= GPB_RST_DIR;
      analog_select_control <= GPB_RST_ANALOG; // [R5]
      first_port_latch <= GPB_RST_LATCH;
      second_port_latch <= GPB_RST_LATCH;
      irq_mask <= GPB_RST_FLAGS;
    end else if (wr_en) begin
      case (wr_idx)
        GPB_IDX_OPTION: option_control <= wd_q;
        GPB_IDX_PB_DIR: first_port_direction <= wd_q;
        GPB_IDX_PC_DIR: second_port_direction <= wd_q;
        GPB_IDX_ANALOG: analog_select_control <= wd_q;
        GPB_IDX_PB_DATA: first_port_latch <= wd_q; // [R17]
        GPB_IDX_PC_DATA: second_port_latch <= wd_q; // [R17]
        GPB_IDX_IRQ_MASK: irq_mask <= wd_q[1:0];
        default: irq_mask <= irq_mask;
      endcase
    end
  end

  // Change snapshot and interrupt flags. Polling the data register also
  // refreshes the snapshot, which can hide a short key press. [R11]
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      change_snapshot <= 8'h00;
      ext_pin_q <= 1'b0;
      interrupt_control <= GPB_RST_FLAGS;
      irq_status <= GPB_RST_FLAGS;
    end else begin
      if (pb_touch) begin
        change_snapshot <= pb_digital; // [R9]
      end
      ext_pin_q <= ext_pin;
      interrupt_control <= next_intctl;
      irq_status <= next_status;
    end
  end

  // Registered pin drive, wake and interrupt outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pb_out <= 8'h00;
      pb_oe <= 8'h00;
      pb_pullup <= 8'h00;
      pc_out <= 8'h00;
      pc_oe <= 8'h00;
      wake <= 1'b0;
      irq <= 1'b0;
    end else begin
      pb_out <= next_pb_out;
      pb_oe <= ~eff_dir_b; // [R1] [R13]
      pb_pullup <= next_pb_pullup;
      pc_out <= next_pc_out;
      pc_oe <= ~eff_dir_c; // [R1] [R16]
      wake <= sleep_mode & interrupt_control[GPB_FLAG_CHANGE]; // [R8]
      irq <= |(irq_status & irq_mask);
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pullup_not_driving: assert property ( // [R3]
    (pb_pullup & pb_oe) == 8'h00)
    else $error("pull-up on while pin drives");

  a_pullup_global_off: assert property ( // [R2]
    option_control[GPB_OPT_PULLUP_N] |=> pb_pullup == 8'h00)
    else $error("pull-up on while global enable is off");

  a_dir_to_drive: assert property ( // [R1]
    ##1 pb_oe == ~$past(eff_dir_b))
    else $error("first port drive does not follow direction");

  a_flag_on_mismatch: assert property ( // [R7]
    mismatch |=> interrupt_control[GPB_FLAG_CHANGE])
    else $error("mismatch did not set change flag");

  a_clear_loses_set: assert property ( // [R10]
    (mismatch && wr_en && wr_idx == GPB_IDX_INTCTL)
    |=> interrupt_control[GPB_FLAG_CHANGE] ##1
        (interrupt_control[GPB_FLAG_CHANGE] || !$past(mismatch)))
    else $error("software clear won over a lasting mismatch");

  a_snapshot_refresh: assert property ( // [R9]
    pb_touch |=> change_snapshot == $past(pb_digital))
    else $error("snapshot not refreshed by port access");

  a_ext_edge_flag: assert property ( // [R12]
    (option_control[GPB_OPT_EDGE] && $rose(ext_pin))
    |=> interrupt_control[GPB_FLAG_EXT])
    else $error("rising edge on pin 0 missed");

  a_wake_on_change: assert property ( // [R8]
    (sleep_mode && interrupt_control[GPB_FLAG_CHANGE]) |=> wake)
    else $error("change flag did not wake the core");

  a_analog_reads_zero: assert property ( // [R5]
    (pb_digital & ~analog_select_control) == 8'h00)
    else $error("analog pin reads as one");

  a_upper_only: assert property ( // [R6]
    (mismatch == 1'b0) || ((monitored & 8'h0F) == 8'h00 &&
     ((pb_digital ^ change_snapshot) & monitored) != 8'h00))
    else $error("change compare saw a lower or output pin");

  a_pc_out_select: assert property ( // [R15]
    ##1 ((pc_out ^ $past(pc_periph.dout)) & $past(pc_periph.own)) == 8'h00)
    else $error("owned second-port pin misses peripheral output");

  a_pc_latch_select: assert property ( // [R15]
    ##1 ((pc_out ^ $past(second_port_latch)) &
         ~$past(pc_periph.own)) == 8'h00)
    else $error("unselected second-port pin misses port latch");

  a_pc_oe_select: assert property ( // [R16]
    ##1 ((pc_oe ^ ~$past(second_port_direction)) &
         ~$past(pc_periph.own)) == 8'h00)
    else $error("peripheral enable acted on an unselected pin");

  a_override_input: assert property ( // [R13]
    ##1 (pb_oe & $past(pb_periph.own) & ~$past(pb_periph.oe)) == 8'h00)
    else $error("pin forced to input still drives");

  a_override_output: assert property ( // [R13]
    ##1 (~pb_oe & $past(pb_periph.own) & $past(pb_periph.oe)) == 8'h00)
    else $error("pin forced to output does not drive");

  a_status_sticky: assert property ( // [R7]
    mismatch |=> irq_status[GPB_FLAG_CHANGE])
    else $error("mismatch did not set change status");

  a_wake_idle: assert property ( // [R8]
    !sleep_mode |=> !wake)
    else $error("wake raised while the core is awake");

endmodule

/* File: gpb_pkg.sv */
// Shared register map, field positions and carrier types of the port block.
package gpb_pkg;

  // Register indices; the bus byte address is four times the index.
  localparam logic [7:0] GPB_IDX_PB_DATA = 8'h06;
  localparam logic [7:0] GPB_IDX_PC_DATA = 8'h07;
  localparam logic [7:0] GPB_IDX_INTCTL = 8'h0B;
  localparam logic [7:0] GPB_IDX_OPTION = 8'h81;
  localparam logic [7:0] GPB_IDX_PB_DIR = 8'h86;
  localparam logic [7:0] GPB_IDX_PC_DIR = 8'h87;
  localparam logic [7:0] GPB_IDX_ANALOG = 8'h9F;
  localparam logic [7:0] GPB_IDX_IRQ_STAT = 8'hA0;
  localparam logic [7:0] GPB_IDX_IRQ_MASK = 8'hA1;

  // Address width needed to reach the highest index as a byte address.
  localparam int GPB_ADDR_W = 10;
  localparam int GPB_IDX_LSB = 2;

  // Reset values.
  localparam logic [7:0] GPB_RST_OPTION = 8'hFF;
  localparam logic [7:0] GPB_RST_DIR = 8'hFF;
  localparam logic [7:0] GPB_RST_ANALOG = 8'h00;
  localparam logic [7:0] GPB_RST_LATCH = 8'h00;
  localparam logic [1:0] GPB_RST_FLAGS = 2'h0;

  // Field positions.
  localparam int GPB_OPT_PULLUP_N = 7;
  localparam int GPB_OPT_EDGE = 6;
  localparam int GPB_FLAG_CHANGE = 0;
  localparam int GPB_FLAG_EXT = 1;

  // Pins that take part in change detection.
  localparam logic [7:0] GPB_UPPER_MASK = 8'hF0;

  // Bus responses.
  localparam logic [1:0] GPB_RESP_OKAY = 2'h0;
  localparam logic [1:0] GPB_RESP_SLVERR = 2'h2;

  // Peripheral claim on the eight pins of one port.
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] dout;
  } gpb_periph_t;

endpackage

/* File: gpb_sync.sv */
// Two-flop synchroniser for a bus of asynchronous pin levels.
module gpb_sync #(
  parameter int W = 8
) (
  input wire logic aclk, // Core clock.
  input wire logic aresetn, // Synchronous reset, active low.
  input wire logic [W-1:0] din, // Raw pin levels.
  output logic [W-1:0] dout // Levels safe to use in the core domain.
);

  logic [W-1:0] stage1;

  // A zero width would leave nothing to sample.
  initial begin
    if (W < 1) begin
      $error("gpb_sync: W must be at least 1");
    end
  end

  // The first stage feeds only the second, so a metastable value
  // never reaches a comparator.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule

/* File: gpb_pin_model.sv */
// Behavioural model of the pads, keypad and drivers outside the port pins.
module gpb_pin_model (
  input wire logic aclk, // Core clock, paces the floating pattern.
  input wire logic [7:0] drv, // Values the block drives.
  input wire logic [7:0] oe, // Block drive enables, high drives.
  input wire logic [7:0] pu_en, // Weak pull-up enables.
  input wire logic [7:0] ext_drv, // Values the outside world drives.
  input wire logic [7:0] ext_en, // Outside drive enables.
  output logic [7:0] pin // Resolved pin levels.
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wiggle = 8'h55;

  // A floating pin toggles every cycle, so no stale level can pass for data.
  always_ff @(posedge aclk) begin
    wiggle <= ~wiggle;
  end

  // The block's driver wins, then the outside driver, then the pull-up.
  assign pin = (oe & drv) | (~oe & ext_en & ext_drv) |
    (~oe & ~ext_en & (pu_en | wiggle));
endmodule

/* File: tb_gpb_port.sv */
// Self-checking bench for the two-port block with change interrupt.
module tb_gpb_port
  import gpb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [9:0] awaddr = 10'h000, araddr = 10'h000;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
  logic arvalid = 1'h0, rready = 1'h0, sleep = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, wake, irq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] pb_in, pb_out, pb_oe, pb_pu, pc_in, pc_out, pc_oe;
  logic [7:0] pb_xd = 8'h00, pb_xe = 8'h00;
  gpb_periph_t pb_per = 24'h0, pc_per = 24'h0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0, n_tests = 0, cyc = 0;
  logic [3:0] r;

  // Clock of 50 ns period.
  always #25 aclk = ~aclk;

  gpb_port DUT (.aclk(aclk), .aresetn(aresetn), .s_awaddr(awaddr),
    .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata),
    .s_wstrb(wstrb), .s_wvalid(wvalid), .s_wready(wready),
    .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready),
    .s_rdata(rdata), .s_rresp(rresp), .s_rvalid(rvalid),
    .s_rready(rready), .pb_in(pb_in), .pb_out(pb_out), .pb_oe(pb_oe),
    .pb_pullup(pb_pu), .pb_periph(pb_per), .pc_in(pc_in),
    .pc_out(pc_out), .pc_oe(pc_oe), .pc_periph(pc_per),
    .sleep_mode(sleep), .wake(wake), .irq(irq));

  gpb_pin_model PBM (.aclk(aclk), .drv(pb_out), .oe(pb_oe),
    .pu_en(pb_pu), .ext_drv(pb_xd), .ext_en(pb_xe), .pin(pb_in));

  // The second port has no pull-ups and nothing driving from outside.
  gpb_pin_model PCM (.aclk(aclk), .drv(pc_out), .oe(pc_oe),
    .pu_en(8'h00), .ext_drv(8'h00), .ext_en(8'h00), .pin(pc_in));

  task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Answers are judged at the falling edge, where they stand settled.
  always @(negedge aclk) begin
    if (rvalid === 1'h1 && rready) begin
      chk({rresp, rdata}, rq.pop_front());
    end
    if (bvalid === 1'h1 && bready) begin
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    end
  end

  // A hang is cut short well beyond the few hundred cycles of the run.
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Each channel is released only at the edge where it is taken.
  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] resp = GPB_RESP_OKAY);
    logic a, w, b;
    @(posedge aclk);
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    bq.push_back(resp);
    b = 1'h0;
    while (b !== 1'h1) begin
      @(negedge aclk);
      a = awvalid & awready;
      w = wvalid & wready;
      b = bvalid;
      @(posedge aclk);
      if (a) awvalid <= 1'h0;
      if (w) wvalid <= 1'h0;
    end
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] d,
                    input logic [1:0] resp = GPB_RESP_OKAY);
    logic a, v;
    @(posedge aclk);
    araddr <= {idx, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    rq.push_back({resp, 24'h0, d});
    v = 1'h0;
    while (v !== 1'h1) begin
      @(negedge aclk);
      a = arvalid & arready;
      v = rvalid;
      @(posedge aclk);
      if (a) arvalid <= 1'h0;
    end
    rready <= 1'h0;
  endtask

  // Main sequence.
  initial begin
    void'($urandom(32'h3E4D));
    repeat (3) @(posedge aclk);
    aresetn <= 1'h1;
    @(negedge aclk);
    chk(pb_oe, 8'h00);
    chk(pb_pu, 8'h00);
    rd(GPB_IDX_OPTION, 8'hFF);
    rd(GPB_IDX_PB_DIR, 8'hFF);
    rd(GPB_IDX_ANALOG, 8'h00);
    rd(GPB_IDX_PB_DATA, 8'h00);
    wr(8'h50, 8'h12, GPB_RESP_SLVERR);
    rd(8'h50, 8'h00, GPB_RESP_SLVERR);
    $display("test reset and unmapped done");
    // Upper pins and pin 0 are driven from outside, pins 3 to 1 drive.
    r = 4'($urandom);
    @(posedge aclk);
    pb_xd <= {r, 4'h0};
    pb_xe <= 8'hF1;
    wr(GPB_IDX_ANALOG, 8'hFF);
    wr(GPB_IDX_PB_DATA, 8'hA5);
    wr(GPB_IDX_PB_DIR, 8'hF1);
    wr(GPB_IDX_OPTION, 8'h7F);
    wt(5);
    @(negedge aclk);
    chk(pb_oe, 8'h0E);
    chk(pb_out[3:1], 3'h2);
    chk(pb_pu, 8'hF1);
    rd(GPB_IDX_PB_DATA, {r, 4'h4});
    wr(GPB_IDX_INTCTL, 8'h00);
    rd(GPB_IDX_INTCTL, 8'h00);
    $display("test direction and pull-ups done");
    // Pin 0 rises and then falls with the rising edge selected.
    @(posedge aclk);
    pb_xd[0] <= 1'h1;
    wt(5);
    rd(GPB_IDX_INTCTL, 8'h02);
    wr(GPB_IDX_INTCTL, 8'h00);
    @(posedge aclk);
    pb_xd[0] <= 1'h0;
    wt(5);
    rd(GPB_IDX_INTCTL, 8'h00);
    $display("test external edge done");
    // Software stays off the data register until a read of it ends the pending change.
    @(posedge aclk);
    pb_xd[7] <= ~r[3];
    wt(5);
    rd(GPB_IDX_INTCTL, 8'h01);
    wr(GPB_IDX_INTCTL, 8'h00);
    rd(GPB_IDX_INTCTL, 8'h01);
    @(negedge aclk);
    chk(irq, 1'h0);
    wr(GPB_IDX_IRQ_MASK, 8'h01);
    wt(2);
    @(negedge aclk);
    chk(irq, 1'h1);
    @(posedge aclk);
    sleep <= 1'h1;
    wt(2);
    @(negedge aclk);
    chk(wake, 1'h1);
    @(posedge aclk);
    sleep <= 1'h0;
    rd(GPB_IDX_IRQ_STAT, 8'h03);
    rd(GPB_IDX_PB_DATA, {~r[3], r[2:0], 4'h4});
    wr(GPB_IDX_INTCTL, 8'h00);
    rd(GPB_IDX_INTCTL, 8'h00);
    rd(GPB_IDX_IRQ_STAT, 8'h01);
    rd(GPB_IDX_IRQ_STAT, 8'h00);
    wt(2);
    @(negedge aclk);
    chk(irq, 1'h0);
    $display("test change interrupt done");
    // Pin 7 is claimed as output, so its differing level is not compared.
    @(posedge aclk);
    pb_per <= {8'h86, 8'h84, r[3], 7'h00};
    wt(2);
    @(negedge aclk);
    chk(pb_oe, 8'h8C);
    chk(pb_out[7], r[3]);
    chk(pb_out[2], 1'h0);
    rd(GPB_IDX_PB_DIR, 8'h73);
    wt(4);
    rd(GPB_IDX_INTCTL, 8'h00);
    // Enables outside the peripheral select must have no effect.
    @(posedge aclk);
    pc_per <= {8'h0F, 8'h35, 8'hA3};
    wr(GPB_IDX_PC_DATA, 8'h5A);
    wr(GPB_IDX_PC_DIR, 8'h0F);
    wt(2);
    @(negedge aclk);
    chk(pc_oe, 8'hF5);
    chk(pc_out, 8'h53);
    $display("test peripheral override done");
    complete_run();
  end
endmodule
